//--- rtl/chip_select_decode.sv
// Purpose: Programmable chip select two and alternate select decoder
// Assumes: Bus pins synchronous to mclk, APB register access
// Notes: Select outputs are registered, one cycle after the bus
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
`include "pcs_defines.svh"
module chip_select_decode
  import pcs_pkg::*;
(
  input wire logic mclk, // Clock, 250 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [19:0] isaAddr, // Bus address
  input wire logic ioRdN, // I/O read strobe, active low
  input wire logic ioWrN, // I/O write strobe, active low
  input wire logic memRdN, // Memory read strobe, active low
  input wire logic memWrN, // Memory write strobe, active low
  input wire logic ioCs16N, // Peripheral I/O 16-bit, active low
  input wire logic memCs16N, // Peripheral memory 16-bit, active low
  input wire logic chipSelectZeroN, // Select zero, active low
  output logic chipSelectTwoN, // Select two, active low
  output logic altSelectN, // Alternate select, active low
  output logic cycle16, // Run a 16-bit cycle
  output logic activityPulse // Activity timer retrigger
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg8_t cs2Mode_q;
  reg8_t cs2Low_q;
  reg8_t cs2High_q;
  reg8_t cs2Upper_q;
  reg8_t altMode_q;
  reg8_t altLow_q;
  reg8_t altHigh_q;
  reg8_t altUpper_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic cs2Act_q;
  logic altAct_q;
  logic cycle16_q;
  logic activity_q;
  logic monHit_q;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire logic [9:0] regIdx;
  wire logic aligned;
  wire logic setup;
  wire logic wrTake;
  wire reg8_t wrByte;
  wire logic hitCs2Mode;
  wire logic hitCs2Low;
  wire logic hitCs2High;
  wire logic hitCs2Upper;
  wire logic hitAltMode;
  wire logic hitAltLow;
  wire logic hitAltHigh;
  wire logic hitAltUpper;
  wire logic hitStatus;
  wire logic mapped;
  logic [7:0] rdByte;

  function automatic logic idxHit(input logic [9:0] idx,
                                  input logic [7:0] want);
    idxHit = (idx == {2'h0, want});
  endfunction : idxHit

  assign regIdx = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setup = psel && !penable;
  assign wrByte = pwdata[7:0];
  assign hitCs2Mode = aligned && idxHit(regIdx, `IDX_CS2_MODE);
  assign hitCs2Low = aligned && idxHit(regIdx, `IDX_CS2_START);
  assign hitCs2High = aligned && idxHit(regIdx, `IDX_CS2_STOP);
  assign hitCs2Upper = aligned && idxHit(regIdx, `IDX_CS2_UPPER);
  assign hitAltMode = aligned && idxHit(regIdx, `IDX_ALT_MODE);
  assign hitAltLow = aligned && idxHit(regIdx, `IDX_ALT_START);
  assign hitAltHigh = aligned && idxHit(regIdx, `IDX_ALT_STOP);
  assign hitAltUpper = aligned && idxHit(regIdx, `IDX_ALT_UPPER);
  assign hitStatus = aligned && idxHit(regIdx, `IDX_STATUS);
  assign mapped = hitCs2Mode || hitCs2Low || hitCs2High ||
                  hitCs2Upper || hitAltMode || hitAltLow ||
                  hitAltHigh || hitAltUpper || hitStatus;
  assign wrTake = psel && penable && pwrite && mapped;

  // Unmapped reads return zero
  always_comb begin
    rdByte = 8'h00;
    if (hitCs2Mode) begin
      rdByte = cs2Mode_q;
    end else if (hitCs2Low) begin
      rdByte = cs2Low_q;
    end else if (hitCs2High) begin
      rdByte = cs2High_q;
    end else if (hitCs2Upper) begin
      rdByte = cs2Upper_q;
    end else if (hitAltMode) begin
      rdByte = altMode_q;
    end else if (hitAltLow) begin
      rdByte = altLow_q;
    end else if (hitAltHigh) begin
      rdByte = altHigh_q;
    end else if (hitAltUpper) begin
      rdByte = altUpper_q;
    end else if (hitStatus) begin
      rdByte = {4'h0, activity_q, cycle16_q, altAct_q, cs2Act_q};
    end
  end

  // Read data and error latched in setup, shown in access phase
  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h0000_0000 : {24'h00_0000, rdByte};
      pslverr_q <= !mapped;
    end
  end

  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign pready = psel && penable;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Bit 6 of each mode register is held at zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      cs2Mode_q <= `RST_CS2_MODE;
      cs2Low_q <= `RST_WINDOW;
      cs2High_q <= `RST_WINDOW;
      cs2Upper_q <= `RST_WINDOW;
      altMode_q <= `RST_ALT_MODE;
      altLow_q <= `RST_WINDOW;
      altHigh_q <= `RST_WINDOW;
      altUpper_q <= `RST_WINDOW;
    end else if (wrTake) begin
      if (hitCs2Mode) cs2Mode_q <= wrByte & `MODE_WR_MASK;
      if (hitCs2Low) cs2Low_q <= wrByte;
      if (hitCs2High) cs2High_q <= wrByte;
      if (hitCs2Upper) cs2Upper_q <= wrByte;
      if (hitAltMode) altMode_q <= wrByte & `MODE_WR_MASK;
      if (hitAltLow) altLow_q <= wrByte;
      if (hitAltHigh) altHigh_q <= wrByte;
      if (hitAltUpper) altUpper_q <= wrByte;
    end
  end

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  wire logic cs2Mem;
  wire logic altMem;
  wire logic [1:0] cs2Qual;
  wire logic [1:0] altQual;
  wire logic [1:0] combineSel;
  wire logic ioRd;
  wire logic ioWr;
  wire logic memRd;
  wire logic memWr;

  assign cs2Mem = cs2Mode_q[`F_SPACE];
  assign altMem = altMode_q[`F_SPACE];
  assign cs2Qual = cs2Mode_q[`F_QUAL_HI:`F_QUAL_LO];
  assign altQual = altMode_q[`F_QUAL_HI:`F_QUAL_LO];
  assign combineSel = altMode_q[`F_AUX_HI:`F_AUX_LO];
  // Strobes turned active high
  assign ioRd = !ioRdN;
  assign ioWr = !ioWrN;
  assign memRd = !memRdN;
  assign memWr = !memWrN;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic cs2Hit;
  wire logic altHit;
  wire logic cs2Act;
  wire logic altRaw;

  // Both selects watch the same address and strobes
  select_window u_cs2Window (
    .spaceMem(cs2Mem),
    .windowLow(cs2Low_q),
    .windowHigh(cs2High_q),
    .upperCompare(cs2Upper_q),
    .addr(isaAddr),
    .hit(cs2Hit)
  );

  select_window u_altWindow (
    .spaceMem(altMem),
    .windowLow(altLow_q),
    .windowHigh(altHigh_q),
    .upperCompare(altUpper_q),
    .addr(isaAddr),
    .hit(altHit)
  );

  select_qualify u_cs2Qualify (
    .qualify(cs2Qual),
    .spaceMem(cs2Mem),
    .hit(cs2Hit),
    .ioRd(ioRd),
    .ioWr(ioWr),
    .memRd(memRd),
    .memWr(memWr),
    .active(cs2Act)
  );

  select_qualify u_altQualify (
    .qualify(altQual),
    .spaceMem(altMem),
    .hit(altHit),
    .ioRd(ioRd),
    .ioWr(ioWr),
    .memRd(memRd),
    .memWr(memWr),
    .active(altRaw)
  );

  // ----------------------------------------------------------------
  // Combine, width and activity
  // ----------------------------------------------------------------
  wire logic combineTerm;
  wire logic altAct;
  wire logic cs2Wide;
  wire logic altWide;
  wire logic wide;
  wire logic monHit;

  // Width bit forces 16 bits, else the reply of the select's space
  function automatic logic wantWide(input logic widthBit,
                                    input logic spaceMem,
                                    input logic ioCs16,
                                    input logic memCs16);
    wantWide = widthBit || (spaceMem ? memCs16 : ioCs16);
  endfunction : wantWide

  // Reserved encoding behaves as no combine
  assign combineTerm = (combineSel == `COMB_ZERO) ? !chipSelectZeroN :
                       (combineSel == `COMB_TWO) ? cs2Act : 1'b1;
  assign altAct = altRaw && combineTerm;
  assign cs2Wide = cs2Act && wantWide(cs2Mode_q[`F_WIDTH], cs2Mem,
                                      !ioCs16N, !memCs16N);
  assign altWide = altAct && wantWide(altMode_q[`F_WIDTH], altMem,
                                      !ioCs16N, !memCs16N);
  assign wide = cs2Wide || altWide;
  assign monHit = (cs2Act && cs2Mode_q[`F_MONITOR]) ||
                  (altAct && altMode_q[`F_MONITOR]);

  // One pulse per access, on the rising edge of a monitored hit
  always_ff @(posedge mclk) begin
    if (rst) begin
      cs2Act_q <= 1'b0;
      altAct_q <= 1'b0;
      cycle16_q <= 1'b0;
      monHit_q <= 1'b0;
      activity_q <= 1'b0;
    end else begin
      cs2Act_q <= cs2Act;
      altAct_q <= altAct;
      cycle16_q <= wide;
      monHit_q <= monHit;
      activity_q <= monHit && !monHit_q;
    end
  end

  assign chipSelectTwoN = !cs2Act_q;
  assign altSelectN = !altAct_q;
  assign cycle16 = cycle16_q;
  assign activityPulse = activity_q;

endmodule : chip_select_decode

//--- rtl/pcs_defines.svh
// Purpose: Register indices, field positions and reset values
// Assumes: Byte address of a register is four times its index
// Notes: Definitions only
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define IDX_CS2_MODE 8'h28
`define IDX_CS2_START 8'h29
`define IDX_CS2_STOP 8'h2a
`define IDX_CS2_UPPER 8'h2b
`define IDX_ALT_MODE 8'h2c
`define IDX_ALT_START 8'h2d
`define IDX_ALT_STOP 8'h2e
`define IDX_ALT_UPPER 8'h2f
`define IDX_STATUS 8'h31

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define F_SPACE 7
`define F_WIDTH 5
`define F_MONITOR 4
`define F_AUX_HI 3
`define F_AUX_LO 2
`define F_QUAL_HI 1
`define F_QUAL_LO 0
`define MODE_WR_MASK 8'hbf

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_CS2_MODE 8'h00
`define RST_ALT_MODE 8'h0c
`define RST_WINDOW 8'h00

// ----------------------------------------------------------------
// Combine select encodings
// ----------------------------------------------------------------
`define COMB_ZERO 2'h0
`define COMB_TWO 2'h2

`endif

//--- rtl/pcs_pkg.sv
// Purpose: Shared types of the chip select decoder
// Assumes: Nothing beyond the defines header
// Notes: Qualify encodings are those of the mode fields
package pcs_pkg;

  typedef enum logic [1:0] {
    QUAL_OFF = 2'h0,
    QUAL_READ = 2'h1,
    QUAL_WRITE = 2'h2,
    QUAL_DECODE = 2'h3
  } qualify_e;

  typedef logic [7:0] reg8_t;

endpackage : pcs_pkg

//--- rtl/select_window.sv
// Purpose: Address window match for one programmable select
// Assumes: Address is sampled as synchronous to mclk
// Notes: Purely combinational
`timescale 1ns/10ps
module select_window
  import pcs_pkg::*;
(
  input wire logic spaceMem, // 1 memory space, 0 I/O space
  input wire reg8_t windowLow, // Lowest matching value
  input wire reg8_t windowHigh, // Highest matching value
  input wire reg8_t upperCompare, // Upper address compare
  input wire logic [19:0] addr, // Bus address
  output logic hit // Address lies inside window
);

  function automatic logic inRange(input reg8_t v, input reg8_t lo,
                                   input reg8_t hi);
    inRange = (v >= lo) && (v <= hi);
  endfunction : inRange

  wire reg8_t cmpField;
  wire logic rangeOk;
  wire logic upperIo;
  wire logic upperMem;
  wire logic upperOk;

  assign cmpField = spaceMem ? addr[15:8] : addr[7:0];
  assign rangeOk = inRange(cmpField, windowLow, windowHigh);
  assign upperIo = (addr[15:8] == upperCompare);
  assign upperMem = (addr[19:16] == upperCompare[3:0]);
  assign upperOk = spaceMem ? upperMem : upperIo;
  assign hit = rangeOk && upperOk;

endmodule : select_window

//--- rtl/select_qualify.sv
// Purpose: Strobe qualification of one programmable select
// Assumes: Strobes are active high here
// Notes: Purely combinational
`timescale 1ns/10ps
module select_qualify
  import pcs_pkg::*;
(
  input wire logic [1:0] qualify, // Qualify field
  input wire logic spaceMem, // 1 memory space, 0 I/O space
  input wire logic hit, // Window match
  input wire logic ioRd, // I/O read strobe
  input wire logic ioWr, // I/O write strobe
  input wire logic memRd, // Memory read strobe
  input wire logic memWr, // Memory write strobe
  output logic active // Select asserted
);

  wire logic rdStrobe;
  wire logic wrStrobe;
  wire qualify_e mode;

  assign mode = qualify_e'(qualify);
  assign rdStrobe = spaceMem ? memRd : ioRd;
  assign wrStrobe = spaceMem ? memWr : ioWr;

  always_comb begin
    case (mode)
      QUAL_OFF: active = 1'b0;
      QUAL_READ: active = hit && rdStrobe;
      QUAL_WRITE: active = hit && wrStrobe;
      QUAL_DECODE: active = hit;
      default: active = 1'b0;
    endcase
  end

endmodule : select_qualify

//--- tb/cs_decode_chk_sva.sv
// Purpose: Port checker of the chip select decoder
// Assumes: Zero wait APB, selects one cycle after the bus inputs
// Notes: Shadows the select two mode register from APB writes
`timescale 1ns/10ps
module cs_decode_chk (
  input wire logic mclk, // clock
  input wire logic rst, // reset
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // write
  input wire logic [11:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic ioRdN, // io read
  input wire logic ioWrN, // io write
  input wire logic memRdN, // mem read
  input wire logic memWrN, // mem write
  input wire logic chipSelectTwoN, // select two
  input wire logic altSelectN, // alt select
  input wire logic cycle16, // wide cycle
  input wire logic activityPulse // activity
);
  logic [7:0] mode_q;
  logic rdN, wrN, wideBit;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  assign rdN = mode_q[7] ? memRdN : ioRdN;
  assign wrN = mode_q[7] ? memWrN : ioWrN;
  assign wideBit = mode_q[5];
  always_ff @(posedge mclk) begin
    if (rst) mode_q <= 8'h00;
    else if (psel && penable && pwrite && paddr == 12'h0a0) mode_q <= pwdata[7:0];
  end
  sequence s_acc;
    psel && penable;
  endsequence
  a_ready_access: assert property (pready == (psel && penable))
    else $error("ready not tied to access phase");
  a_err_unaligned: assert property (s_acc ##0 (paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unaligned access without error");
  a_rdata_upper: assert property (s_acc ##0 !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_off_never: assert property (mode_q[1:0] == 2'h0 |=> chipSelectTwoN)
    else $error("select two with mode off");
  a_read_qual: assert property (mode_q[1:0] == 2'h1 && rdN |=> chipSelectTwoN)
    else $error("select two without read strobe");
  a_write_qual: assert property (mode_q[1:0] == 2'h2 && wrN |=> chipSelectTwoN)
    else $error("select two without write strobe");
  a_width_force: assert property (!chipSelectTwoN && $past(wideBit) |-> cycle16)
    else $error("wide select without 16-bit cycle");
  a_pulse_single: assert property (activityPulse |=> !activityPulse)
    else $error("activity pulse too long");
  a_pulse_cause: assert property (activityPulse |-> !chipSelectTwoN || !altSelectN)
    else $error("activity without select");
  a_reset_idle: assert property (disable iff (1'b0) rst |=> chipSelectTwoN && altSelectN)
    else $error("select active after reset");
endmodule : cs_decode_chk
bind chip_select_decode cs_decode_chk cs_decode_chk_i (.mclk(mclk),
  .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ioRdN(ioRdN), .ioWrN(ioWrN), .memRdN(memRdN),
  .memWrN(memWrN), .chipSelectTwoN(chipSelectTwoN),
  .altSelectN(altSelectN), .cycle16(cycle16),
  .activityPulse(activityPulse));

//--- tb/isa_peripheral.sv
// Purpose: Peripheral answering the 16-bit reply lines
// Assumes: Peripheral decodes its own address space
// Notes: Reply lines are driven high when not asserted
`timescale 1ns/10ps
module isa_peripheral (
  input wire logic wide, // peripheral is 16 bits
  input wire logic memSpace, // peripheral lives in memory
  input wire logic claimed, // address belongs to it
  output logic ioCs16N, // io 16-bit reply
  output logic memCs16N // mem 16-bit reply
);
  assign ioCs16N = !(wide && claimed && !memSpace);
  assign memCs16N = !(wide && claimed && memSpace);
endmodule : isa_peripheral

//--- tb/tb_chip_select_decode.sv
// Purpose: Self-checking bench of the chip select decoder
// Assumes: Zero wait APB, outputs one cycle after bus inputs
// Notes: Random windows with single byte and full range corners
`timescale 1ns/10ps
module tb_chip_select_decode;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [19:0] isaAddr;
  logic ioRdN, ioWrN, memRdN, memWrN, ioCs16N, memCs16N, chipSelectZeroN;
  logic chipSelectTwoN, altSelectN, cycle16, activityPulse;
  logic wide, pMem, claimed;
  int err_total, compares;
  chip_select_decode chip_select_decode_i (.mclk(mclk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .isaAddr(isaAddr), .ioRdN(ioRdN), .ioWrN(ioWrN), .memRdN(memRdN),
    .memWrN(memWrN), .ioCs16N(ioCs16N), .memCs16N(memCs16N),
    .chipSelectZeroN(chipSelectZeroN), .chipSelectTwoN(chipSelectTwoN),
    .altSelectN(altSelectN), .cycle16(cycle16),
    .activityPulse(activityPulse));
  isa_peripheral isa_peripheral_i (.wide(wide), .memSpace(pMem),
    .claimed(claimed), .ioCs16N(ioCs16N), .memCs16N(memCs16N));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nxt
  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction : ba
  function automatic logic inWin(input logic [7:0] m, lo, hi, up,
      input logic [19:0] a);
    logic [7:0] f;
    f = m[7] ? a[15:8] : a[7:0];
    return f >= lo && f <= hi && (m[7] ? a[19:16] == up[3:0] : a[15:8] == up);
  endfunction : inWin
  function automatic logic qual(input logic [1:0] q, input logic h, r, w);
    case (q)
      2'h0: return 1'b0;
      2'h1: return h && r;
      2'h2: return h && w;
      default: return h;
    endcase
  endfunction : qual
  task automatic chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic end_of_test();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (40000) @(posedge mclk);
    err_total++;
    end_of_test();
  end
  initial begin
    logic [7:0] m, lo, hi, up, f;
    logic [1:0] cb;
    logic [19:0] a;
    logic s2, sa, h, w;
    {psel, penable, pwrite, paddr, pwdata, isaAddr} = '0;
    {ioRdN, ioWrN, memRdN, memWrN, chipSelectZeroN} = '1;
    {wide, pMem, claimed} = '0;
    {err_total, compares} = '0;
    rst = 1'b1;
    seed = 32'hb9c7bc26;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ba(8'h28 + 8'(i)), 8'h00);
      chk(rd, i == 4 ? 32'h0c : 32'h0);
    end
    apb(1'b0, 12'h0fc, 8'h00);
    chk(e, 1'b1);
    apb(1'b1, 12'h0a1, 8'h03);
    chk(e, 1'b1);
    for (int i = 0; i < 200; i++) begin
      seed = nxt(seed);
      {m, lo, hi, up} = seed;
      seed = nxt(seed);
      cb = seed[3:2];
      {wide, pMem} <= seed[1:0];
      if (i < 8) {m[1:0], lo, hi} = {2'(i), i > 3 ? 16'h1010 : 16'h00ff};
      apb(1'b1, ba(8'h28), 8'h00);
      apb(1'b1, ba(8'h2c), 8'h0c);
      isaAddr <= {~up[3:0], ~up, 8'h00};
      apb(1'b1, ba(8'h29), lo);
      apb(1'b1, ba(8'h2a), hi);
      apb(1'b1, ba(8'h2b), up);
      apb(1'b1, ba(8'h2d), lo);
      apb(1'b1, ba(8'h2e), hi);
      apb(1'b1, ba(8'h2f), up);
      apb(1'b1, ba(8'h28), m);
      apb(1'b0, ba(8'h28), 8'h00);
      chk(rd, {24'h0, m & 8'hbf});
      apb(1'b1, ba(8'h2c), {m[7:4], cb, m[1:0]});
      seed = nxt(seed);
      a = seed[19:0];
      f = hi < lo ? seed[31:24] : lo + 8'(seed[31:24] % (hi - lo + 1));
      if (seed[20]) a = m[7] ? {up[3:0], f, seed[7:0]} : {seed[19:16], up, f};
      {ioRdN, ioWrN, memRdN, memWrN, chipSelectZeroN} <= seed[25:21];
      h = inWin(m, lo, hi, up, a);
      s2 = qual(m[1:0], h, !(m[7] ? seed[23] : seed[25]),
        !(m[7] ? seed[22] : seed[24]));
      sa = s2 && (cb != 2'h0 || !seed[21]);
      w = (s2 || sa) && (m[5] || (wide && pMem == m[7]));
      claimed <= h;
      isaAddr <= a;
      @(posedge mclk);
      #1;
      chk(chipSelectTwoN, !s2);
      chk(altSelectN, !sa);
      chk(cycle16, w);
      chk(activityPulse, (s2 || sa) && m[4]);
      apb(1'b0, ba(8'h31), 8'h00);
      chk(rd, {24'h0, 5'h00, w, sa, s2});
    end
    end_of_test();
  end
endmodule : tb_chip_select_decode
